// ==== logic/conv_done_detect.sv ====
// Raises a one-cycle completion pulse when a proximity conversion ends.
// Assumes the conversion flags come from logic on the same clock.
`timescale 1ns/100ps
module conv_done_detect (
    input wire logic clk,
    input wire logic rst,
    input wire logic conv_running,
    input wire logic prox_conv,
    output logic done_q
);
    typedef enum logic [1:0] {IDLE, PROX_RUN, OTHER_RUN} conv_state_t;
    conv_state_t state_q, state_d;
    logic done_d;

    // Kind of conversion is latched at start; touch runs never complete here
    always_comb begin
        state_d = state_q;
        done_d = 1'b0;
        case (state_q)
            IDLE: begin
                if (conv_running) begin
                    state_d = prox_conv ? PROX_RUN : OTHER_RUN;
                end
            end
            PROX_RUN: begin
                if (!conv_running) begin
                    state_d = IDLE;
                    done_d = 1'b1;
                end
            end
            OTHER_RUN: begin
                if (!conv_running) begin
                    state_d = IDLE;
                end
            end
            default: begin
                state_d = IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= IDLE;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            done_q <= done_d;
        end
    end

    conv_done_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == PROX_RUN && !conv_running) |=> done_q)
        else $error("Proximity conversion end gave no done pulse");
    touch_no_done_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == OTHER_RUN) |=> !done_q)
        else $error("Done pulse after a touch conversion");
    prox_end_c: cover property (@(posedge clk) disable iff (rst)
        $rose(done_q));
endmodule

// ==== logic/front_decode.sv ====
// Decodes the configuration bytes into registered front-end selects.
// Assumes the bytes are register outputs on the same clock.
`timescale 1ns/100ps
module front_decode
    import prox_regs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sensfreq,
    input wire logic [7:0] routing,
    input wire logic [7:0] boost,
    output front_sel_t sel_q
);
    front_sel_t sel_d;
    logic [2:0] freq;
    logic [3:0] sensor;
    logic [3:0] shield;
    logic [2:0] bst;

    // Reserved codes select nothing and raise the fault flag
    always_comb begin
        freq = sensfreq[FREQ_MSB:FREQ_LSB];
        sensor = routing[SENSOR_MSB:SENSOR_LSB];
        shield = routing[SHIELD_MSB:SHIELD_LSB];
        bst = boost[BOOST_MSB:BOOST_LSB];
        sel_d = '0;
        sel_d.sense_level = sensfreq[SENS_MSB:SENS_LSB];
        sel_d.freq_onehot = {freq == FREQ_150K, freq == FREQ_112K,
            freq == FREQ_90K, freq == FREQ_64K};
        sel_d.sensor_onehot = {sensor == ROUTE_Y, sensor == ROUTE_X,
            sensor == ROUTE_SECOND_AUX_INPUT, sensor == ROUTE_FIRST_AUX_INPUT};
        sel_d.shield_onehot = {shield == ROUTE_Y, shield == ROUTE_X,
            shield == ROUTE_THIRD_AUX_INPUT};
        sel_d.boost_en = (bst == BOOST_ON);
        sel_d.cfg_fault = (sel_d.freq_onehot == 4'h0)
            || (sel_d.sensor_onehot == 4'h0 && sensor != ROUTE_NONE)
            || (sel_d.shield_onehot == 3'h0 && shield != ROUTE_NONE)
            || (bst != BOOST_ON && bst != BOOST_OFF);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sel_q <= '0;
        end else begin
            sel_q <= sel_d;
        end
    end
endmodule

// ==== logic/prox_monitor_regs.sv ====
// Proximity monitor and configuration register bank, byte wide.
// Assumes the serial interface hands over one decoded access per cycle,
// and the sensing engine holds its results steady while idle.
`timescale 1ns/100ps
// Contract
// - Useful value, 12-bit signed, upper 4 bits then lower byte.
// - Average, 12-bit signed, upper 4 bits then lower byte, rest zero.
// - Differential, 13-bit signed, upper 5 bits then lower byte.
// - Compensation offset, 16 bits, upper byte then lower byte, read-only.
// - Sensitivity field bits 6:4, reset 000, eight levels.
// - Frequency field bits 3:1 selects 64, 90, 112 or 150 kHz.
// - Sensor routing bits 7:4: none, first_aux_input, second_aux_input, X plate, Y plate.
// - Shield routing bits 3:0: none, third_aux_input, X plate, Y plate.
// - Boost field bits 5:3: 100 enables, 110 disables.
// - Conversion done fires when a proximity conversion stops running.
module prox_monitor_regs
    import prox_regs_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    // Register access from the serial interface
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [7:0] REG_RDATA_OUT,
    output logic REG_RVALID_OUT,
    // Sensing engine
    input wire logic CONV_RUNNING_IN,
    input wire logic PROX_CONV_IN,
    input wire mon_values_t MON_IN,
    output logic CONV_DONE_OUT,
    // Front-end controls
    output front_sel_t FRONT_SEL_OUT,
    output logic [2:0] BOOST_TRIM_OUT,
    output logic [7:0] INIT_TRIM_OUT
);
    // ****************************************
    // State
    // ****************************************
    mon_values_t mon_q, mon_d;
    logic [7:0] sensfreq_q, sensfreq_d;
    logic [7:0] routing_q, routing_d;
    logic [7:0] boost_q, boost_d;
    logic [7:0] init_val_q, init_val_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic done_q;
    front_sel_t sel_q;

    // ****************************************
    // Conversion completion and front decode
    // ****************************************
    conv_done_detect u_conv_done (
        .clk(CLK_SYS_IN),
        .rst(RST_IN),
        .conv_running(CONV_RUNNING_IN),
        .prox_conv(PROX_CONV_IN),
        .done_q(done_q)
    );

    front_decode u_front_decode (
        .clk(CLK_SYS_IN),
        .rst(RST_IN),
        .sensfreq(sensfreq_q),
        .routing(routing_q),
        .boost(boost_q),
        .sel_q(sel_q)
    );

    // ****************************************
    // Monitoring capture
    // ****************************************
    // All four values load on the same edge, so a host reading the halves
    // between two completions never mixes two conversions.
    always_comb begin
        mon_d = mon_q;
        if (done_q) begin
            mon_d = MON_IN;
        end
    end

    // ****************************************
    // Configuration writes
    // ****************************************
    // Monitoring and spare offsets have no write path at all.
    always_comb begin
        sensfreq_d = sensfreq_q;
        routing_d = routing_q;
        boost_d = boost_q;
        init_val_d = init_val_q;
        if (REG_WR_IN) begin
            case (REG_ADDR_IN)
                SENSFREQ_ADDR: begin
                    sensfreq_d = REG_WDATA_IN & SENSFREQ_WMASK;
                end
                ROUTING_ADDR: begin
                    routing_d = REG_WDATA_IN;
                end
                BOOST_ADDR: begin
                    boost_d = REG_WDATA_IN & BOOST_WMASK;
                end
                INIT_VAL_ADDR: begin
                    init_val_d = REG_WDATA_IN;
                end
                default: begin
                    init_val_d = init_val_q;
                end
            endcase
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    // Read data is registered; unmapped offsets answer 0x00.
    always_comb begin
        rvalid_d = REG_RD_IN;
        rdata_d = 8'h00;
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                USEFUL_HI_ADDR: begin
                    rdata_d = {4'h0, mon_q.useful[11:8]};
                end
                USEFUL_LO_ADDR: begin
                    rdata_d = mon_q.useful[7:0];
                end
                AVG_HI_ADDR: begin
                    rdata_d = {4'h0, mon_q.average[11:8]};
                end
                AVG_LO_ADDR: begin
                    rdata_d = mon_q.average[7:0];
                end
                DIFF_HI_ADDR: begin
                    rdata_d = {3'h0, mon_q.diff[12:8]};
                end
                DIFF_LO_ADDR: begin
                    rdata_d = mon_q.diff[7:0];
                end
                OFFS_HI_ADDR: begin
                    rdata_d = mon_q.offset[15:8];
                end
                OFFS_LO_ADDR: begin
                    rdata_d = mon_q.offset[7:0];
                end
                SENSFREQ_ADDR: begin
                    rdata_d = sensfreq_q;
                end
                ROUTING_ADDR: begin
                    rdata_d = routing_q;
                end
                BOOST_ADDR: begin
                    rdata_d = boost_q;
                end
                INIT_VAL_ADDR: begin
                    rdata_d = init_val_q;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            mon_q <= '0;
            sensfreq_q <= SENSFREQ_RST;
            routing_q <= ROUTING_RST;
            boost_q <= BOOST_RST;
            init_val_q <= INIT_VAL_RST;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            mon_q <= mon_d;
            sensfreq_q <= sensfreq_d;
            routing_q <= routing_d;
            boost_q <= boost_d;
            init_val_q <= init_val_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign REG_RDATA_OUT = rdata_q;
    assign REG_RVALID_OUT = rvalid_q;
    assign CONV_DONE_OUT = done_q;
    assign FRONT_SEL_OUT = sel_q;
    // Required init values are passed on raw; the bank does not check them
    assign BOOST_TRIM_OUT = boost_q[2:0];
    assign INIT_TRIM_OUT = init_val_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (RST_IN);

    useful_high_fmt_a: assert property (
        REG_RD_IN && REG_ADDR_IN == USEFUL_HI_ADDR && !done_q
        |=> REG_RVALID_OUT && REG_RDATA_OUT == {4'h0, mon_q.useful[11:8]})
        else $error("Useful upper read wrong");
    avg_high_fmt_a: assert property (
        REG_RD_IN && REG_ADDR_IN == AVG_HI_ADDR
        |=> REG_RDATA_OUT[7:4] == 4'h0
        && REG_RDATA_OUT[3:0] == $past(mon_q.average[11:8]))
        else $error("Average upper read wrong");
    diff_high_fmt_a: assert property (
        REG_RD_IN && REG_ADDR_IN == DIFF_HI_ADDR
        |=> REG_RDATA_OUT == {3'h0, $past(mon_q.diff[12:8])})
        else $error("Differential upper read wrong");
    offset_bytes_a: assert property (
        REG_RD_IN && REG_ADDR_IN == OFFS_LO_ADDR
        |=> REG_RDATA_OUT == $past(mon_q.offset[7:0]))
        else $error("Offset lower read wrong");
    sense_level_a: assert property (
        REG_WR_IN && REG_ADDR_IN == SENSFREQ_ADDR
        |=> ##1 FRONT_SEL_OUT.sense_level == $past(REG_WDATA_IN[6:4], 2))
        else $error("Sensitivity not applied two cycles after write");
    freq_150k_a: assert property (
        REG_WR_IN && REG_ADDR_IN == SENSFREQ_ADDR
        && REG_WDATA_IN[3:1] == FREQ_150K
        |=> ##1 FRONT_SEL_OUT.freq_onehot == 4'h8)
        else $error("150 kHz select wrong");
    sensor_y_a: assert property (
        REG_WR_IN && REG_ADDR_IN == ROUTING_ADDR
        && REG_WDATA_IN[7:4] == ROUTE_Y
        |=> ##1 FRONT_SEL_OUT.sensor_onehot == 4'h8)
        else $error("Sensor Y plate select wrong");
    shield_third_aux_input_a: assert property (
        REG_WR_IN && REG_ADDR_IN == ROUTING_ADDR
        && REG_WDATA_IN[3:0] == ROUTE_THIRD_AUX_INPUT
        |=> ##1 FRONT_SEL_OUT.shield_onehot == 3'h1)
        else $error("Shield third_aux_input select wrong");
    boost_decode_a: assert property (
        ##1 FRONT_SEL_OUT.boost_en == ($past(boost_q[5:3]) == BOOST_ON))
        else $error("Boost enable does not follow field");
    capture_whole_a: assert property (
        done_q |=> mon_q == $past(MON_IN))
        else $error("Monitoring values not captured on done");
    ro_hold_a: assert property (
        !done_q |=> $stable(mon_q))
        else $error("Monitoring values changed without a conversion");
    spare_zero_a: assert property (
        REG_RD_IN && REG_ADDR_IN == SPARE_ADDR |=> REG_RDATA_OUT == 8'h00)
        else $error("Spare register reads nonzero");
    cfg_hold_a: assert property (
        !(REG_WR_IN && REG_ADDR_IN == BOOST_ADDR) |=> $stable(boost_q))
        else $error("Boost register changed without a write");

    useful_low_fmt_a: assert property (
        REG_RD_IN && REG_ADDR_IN == USEFUL_LO_ADDR
        |=> REG_RDATA_OUT == $past(mon_q.useful[7:0]))
        else $error("Useful lower read wrong");
    avg_low_fmt_a: assert property (
        REG_RD_IN && REG_ADDR_IN == AVG_LO_ADDR
        |=> REG_RDATA_OUT == $past(mon_q.average[7:0]))
        else $error("Average lower read wrong");
    diff_low_fmt_a: assert property (
        REG_RD_IN && REG_ADDR_IN == DIFF_LO_ADDR
        |=> REG_RDATA_OUT == $past(mon_q.diff[7:0]))
        else $error("Differential lower read wrong");
    offset_high_a: assert property (
        REG_RD_IN && REG_ADDR_IN == OFFS_HI_ADDR
        |=> REG_RDATA_OUT == $past(mon_q.offset[15:8]))
        else $error("Offset upper read wrong");
    // Decode checks look two edges out: one edge stores the byte,
    // the next registers the decoded selects.
    freq_64k_a: assert property (
        REG_WR_IN && REG_ADDR_IN == SENSFREQ_ADDR
        && REG_WDATA_IN[3:1] == FREQ_64K
        |=> ##1 FRONT_SEL_OUT.freq_onehot == 4'h1)
        else $error("64 kHz select wrong");
    freq_reserved_a: assert property (
        REG_WR_IN && REG_ADDR_IN == SENSFREQ_ADDR
        && (REG_WDATA_IN[3:1] < FREQ_64K || REG_WDATA_IN[3:1] > FREQ_150K)
        |=> ##1 FRONT_SEL_OUT.freq_onehot == 4'h0 && FRONT_SEL_OUT.cfg_fault)
        else $error("Reserved frequency code not refused");
    sensor_first_aux_input_a: assert property (
        REG_WR_IN && REG_ADDR_IN == ROUTING_ADDR
        && REG_WDATA_IN[7:4] == ROUTE_FIRST_AUX_INPUT
        |=> ##1 FRONT_SEL_OUT.sensor_onehot == 4'h1)
        else $error("Sensor first aux select wrong");
    shield_y_a: assert property (
        REG_WR_IN && REG_ADDR_IN == ROUTING_ADDR
        && REG_WDATA_IN[3:0] == ROUTE_Y
        |=> ##1 FRONT_SEL_OUT.shield_onehot == 3'h4)
        else $error("Shield Y plate select wrong");
    boost_reserved_a: assert property (
        boost_q[5:3] != BOOST_ON && boost_q[5:3] != BOOST_OFF
        |=> FRONT_SEL_OUT.cfg_fault)
        else $error("Reserved boost code not flagged");
    sensfreq_store_a: assert property (
        REG_WR_IN && REG_ADDR_IN == SENSFREQ_ADDR
        |=> sensfreq_q == {1'b0, $past(REG_WDATA_IN[6:1]), 1'b0})
        else $error("Sensitivity register reserved bits stored");
    boost_store_a: assert property (
        REG_WR_IN && REG_ADDR_IN == BOOST_ADDR
        |=> boost_q == {2'b00, $past(REG_WDATA_IN[5:0])})
        else $error("Boost register reserved bits stored");
    init_hold_a: assert property (
        !(REG_WR_IN && REG_ADDR_IN == INIT_VAL_ADDR) |=> $stable(init_val_q))
        else $error("Init register changed without a write");
    idle_read_a: assert property (
        !REG_RD_IN |=> !REG_RVALID_OUT && REG_RDATA_OUT == 8'h00)
        else $error("Read answer without a read strobe");

    capture_c: cover property (done_q ##1 REG_RD_IN);
    boost_on_c: cover property (FRONT_SEL_OUT.boost_en);
    fault_c: cover property (FRONT_SEL_OUT.cfg_fault);
    plate_sensor_c: cover property (
        FRONT_SEL_OUT.sensor_onehot == 4'h4 && !FRONT_SEL_OUT.boost_en);
endmodule

// ==== logic/prox_regs_pkg.sv ====
// Constants and carrier types for the proximity monitor register bank.
// Assumes byte-wide register accesses already decoded by the serial port.
package prox_regs_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] USEFUL_HI_ADDR = 8'h15;
    localparam logic [7:0] USEFUL_LO_ADDR = 8'h16;
    localparam logic [7:0] AVG_HI_ADDR = 8'h17;
    localparam logic [7:0] AVG_LO_ADDR = 8'h18;
    localparam logic [7:0] DIFF_HI_ADDR = 8'h19;
    localparam logic [7:0] DIFF_LO_ADDR = 8'h1A;
    localparam logic [7:0] OFFS_HI_ADDR = 8'h1B;
    localparam logic [7:0] OFFS_LO_ADDR = 8'h1C;
    localparam logic [7:0] SENSFREQ_ADDR = 8'h1D;
    localparam logic [7:0] ROUTING_ADDR = 8'h1E;
    localparam logic [7:0] BOOST_ADDR = 8'h1F;
    localparam logic [7:0] INIT_VAL_ADDR = 8'h20;
    localparam logic [7:0] SPARE_ADDR = 8'h21;
    // ****************************************
    // Reset values and writable bit masks
    // ****************************************
    localparam logic [7:0] SENSFREQ_RST = 8'h00;
    localparam logic [7:0] ROUTING_RST = 8'h00;
    localparam logic [7:0] BOOST_RST = 8'h00;
    localparam logic [7:0] INIT_VAL_RST = 8'h01;
    localparam logic [7:0] SENSFREQ_WMASK = 8'h7E;
    localparam logic [7:0] BOOST_WMASK = 8'h3F;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int SENS_MSB = 6;
    localparam int SENS_LSB = 4;
    localparam int FREQ_MSB = 3;
    localparam int FREQ_LSB = 1;
    localparam int SENSOR_MSB = 7;
    localparam int SENSOR_LSB = 4;
    localparam int SHIELD_MSB = 3;
    localparam int SHIELD_LSB = 0;
    localparam int BOOST_MSB = 5;
    localparam int BOOST_LSB = 3;
    // ****************************************
    // Field codes
    // ****************************************
    localparam logic [2:0] FREQ_64K = 3'h2;
    localparam logic [2:0] FREQ_90K = 3'h3;
    localparam logic [2:0] FREQ_112K = 3'h4;
    localparam logic [2:0] FREQ_150K = 3'h5;
    localparam logic [3:0] ROUTE_NONE = 4'h0;
    localparam logic [3:0] ROUTE_FIRST_AUX_INPUT = 4'h1;
    localparam logic [3:0] ROUTE_SECOND_AUX_INPUT = 4'h2;
    localparam logic [3:0] ROUTE_THIRD_AUX_INPUT = 4'h3;
    localparam logic [3:0] ROUTE_X = 4'h8;
    localparam logic [3:0] ROUTE_Y = 4'h9;
    localparam logic [2:0] BOOST_ON = 3'h4;
    localparam logic [2:0] BOOST_OFF = 3'h6;
    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [11:0] useful;
        logic [11:0] average;
        logic [12:0] diff;
        logic [15:0] offset;
    } mon_values_t;
    typedef struct packed {
        logic [2:0] sense_level;
        logic [3:0] freq_onehot;
        logic [3:0] sensor_onehot;
        logic [2:0] shield_onehot;
        logic boost_en;
        logic cfg_fault;
    } front_sel_t;
endpackage

// ==== verif/prox_engine_model.sv ====
// Behavioural sensing engine that runs conversions for the register bank.
// Assumes start_in is a one-cycle pulse given only while the model is idle.
`timescale 1ns/100ps
module prox_engine_model
    import prox_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Commands from the bench
    input wire logic start_in,
    input wire logic is_prox_in,
    input wire logic [7:0] run_len_in,
    input wire mon_values_t result_in,
    // Engine side of the bank
    output logic running_out,
    output logic prox_out,
    output mon_values_t mon_out
);
    logic [7:0] cnt_q;
    logic [1:0] hold_q;

    // Results are valid only around the end of a run; at all other times after
    // the first start the inverse is shown so a capture on the wrong cycle is seen.
    always_ff @(posedge clk) begin
        if (rst) begin
            running_out <= 1'b0;
            prox_out <= 1'b0;
            cnt_q <= 8'h00;
            hold_q <= 2'h0;
            mon_out <= '0;
        end else if (start_in) begin
            running_out <= 1'b1;
            prox_out <= is_prox_in;
            cnt_q <= run_len_in;
            mon_out <= ~result_in;
        end else if (running_out) begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
                running_out <= 1'b0;
                mon_out <= result_in;
                hold_q <= 2'h3;
            end
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
            if (hold_q == 2'h1) begin
                mon_out <= ~result_in;
            end
        end
    end
endmodule

// ==== verif/prox_monitor_regs_tb.sv ====
// Self-checking bench for the proximity monitor register bank.
// Assumes the decoded byte access port and one-cycle read answers.
`timescale 1ns/100ps
module prox_monitor_regs_tb
    import prox_regs_pkg::*;
;
    logic clk, rst, wr_en, rd_en, start, is_prox, running, prox, done, rvalid;
    logic [7:0] addr, wdata, rdata, run_len, init_trim;
    logic [2:0] boost_trim;
    mon_values_t result, mon, r1, r2;
    front_sel_t front;
    int fails, checks_done, i;
    bit seen;
    localparam logic [3:0] SC[6] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'h5};
    localparam logic [3:0] SE[6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
    localparam logic [3:0] HC[6] = '{4'h0, 4'h3, 4'h8, 4'h9, 4'h4, 4'h3};
    localparam logic [2:0] HE[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h0, 3'h1};
    localparam logic [3:0] FE[8] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h4, 4'h8,
        4'h0, 4'h0};

    prox_monitor_regs dut (.CLK_SYS_IN(clk), .RST_IN(rst),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr_en),
        .REG_RD_IN(rd_en), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
        .CONV_RUNNING_IN(running), .PROX_CONV_IN(prox), .MON_IN(mon),
        .CONV_DONE_OUT(done), .FRONT_SEL_OUT(front),
        .BOOST_TRIM_OUT(boost_trim), .INIT_TRIM_OUT(init_trim));
    prox_engine_model engine (.clk(clk), .rst(rst), .start_in(start),
        .is_prox_in(is_prox), .run_len_in(run_len), .result_in(result),
        .running_out(running), .prox_out(prox), .mon_out(mon));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen_v,
        input logic [15:0] exp_v);
        checks_done++;
        if (seen_v !== exp_v) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp_v, seen_v);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Front-end selects follow a write one edge after it is taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
        input string what);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        check("read valid", 16'(rvalid), 16'h0001);
        check(what, 16'(rdata), 16'(e));
    endtask

    task automatic chk_mon(input mon_values_t r);
        logic [7:0] e[8];
        e = '{{4'h0, r.useful[11:8]}, r.useful[7:0],
            {4'h0, r.average[11:8]}, r.average[7:0],
            {3'h0, r.diff[12:8]}, r.diff[7:0], r.offset[15:8], r.offset[7:0]};
        for (int k = 0; k < 8; k++) begin
            rd(USEFUL_HI_ADDR + 8'(k), e[k], "monitor byte");
        end
    endtask

    // Bounded wait; a missing proximity pulse ends the run
    task automatic run_conv(input logic p, input mon_values_t r,
        input logic [7:0] len);
        @(posedge clk);
        start <= 1'b1;
        is_prox <= p;
        result <= r;
        run_len <= len;
        @(posedge clk);
        start <= 1'b0;
        seen = 1'b0;
        for (int k = 0; k < 40 && !seen; k++) begin
            @(posedge clk);
            #1;
            seen = (done === 1'b1);
        end
        check("done pulse seen", 16'(seen), 16'(p));
        if (seen) begin
            @(posedge clk);
            #1;
            check("done pulse width", 16'(done), 16'h0000);
        end else if (p) begin
            report_and_stop();
        end
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        fails = 0;
        checks_done = 0;
        rst = 1'b1;
        {wr_en, rd_en, start, is_prox} = 4'h0;
        addr = 8'h00;
        wdata = 8'h00;
        run_len = 8'h05;
        result = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check("init trim", 16'(init_trim), 16'h0001);
        check("reset fault", 16'(front.cfg_fault), 16'h0001);
        chk_mon('0);
        rd(SENSFREQ_ADDR, 8'h00, "sensfreq reset");
        rd(ROUTING_ADDR, 8'h00, "routing reset");
        rd(BOOST_ADDR, 8'h00, "boost reset");
        rd(INIT_VAL_ADDR, 8'h01, "init reset");
        rd(SPARE_ADDR, 8'h00, "spare reset");
        rd(8'h40, 8'h00, "unmapped");
        $display("reset values done");
        for (i = 0; i < 8; i++) begin
            wr(SENSFREQ_ADDR, {1'b1, 3'(i), 3'(i), 1'b1});
            rd(SENSFREQ_ADDR, {1'b0, 3'(i), 3'(i), 1'b0}, "sensfreq");
            check("sense level", 16'(front.sense_level), 16'(i));
            check("freq select", 16'(front.freq_onehot), 16'(FE[i]));
        end
        $display("sensitivity and frequency done");
        wr(BOOST_ADDR, {2'b00, BOOST_OFF, 3'b100});
        for (i = 0; i < 6; i++) begin
            wr(ROUTING_ADDR, {SC[i], HC[i]});
            rd(ROUTING_ADDR, {SC[i], HC[i]}, "routing");
            check("sensor", 16'(front.sensor_onehot), 16'(SE[i]));
            check("shield", 16'(front.shield_onehot), 16'(HE[i]));
        end
        $display("routing done");
        wr(BOOST_ADDR, 8'hFF);
        rd(BOOST_ADDR, 8'h3F, "boost mask");
        check("boost trim", 16'(boost_trim), 16'h0007);
        wr(BOOST_ADDR, {2'b00, BOOST_ON, 3'b100});
        check("boost on", 16'(front.boost_en), 16'h0001);
        check("boost trim", 16'(boost_trim), 16'h0004);
        wr(INIT_VAL_ADDR, 8'h81);
        rd(INIT_VAL_ADDR, 8'h81, "init value");
        check("init trim", 16'(init_trim), 16'h0081);
        wr(SPARE_ADDR, 8'hFF);
        rd(SPARE_ADDR, 8'h00, "spare");
        // Boost goes off before the touch screen becomes the sensor
        wr(SENSFREQ_ADDR, {1'b0, 3'h3, FREQ_150K, 1'b0});
        wr(BOOST_ADDR, {2'b00, BOOST_OFF, 3'b100});
        wr(ROUTING_ADDR, {ROUTE_X, ROUTE_Y});
        check("boost off", 16'(front.boost_en), 16'h0000);
        check("valid config", 16'(front.cfg_fault), 16'h0000);
        $display("boost and init done");
        r1 = '{useful: 12'hA5C, average: 12'h8F1, diff: 13'h1ABC,
            offset: 16'hC3E7};
        r2 = ~r1;
        run_conv(1'b1, r1, 8'h05);
        // Deliberate host misuse: writes to read-only monitor bytes
        wr(USEFUL_HI_ADDR, 8'hFF);
        wr(OFFS_LO_ADDR, 8'h00);
        chk_mon(r1);
        run_conv(1'b0, r2, 8'h03);
        chk_mon(r1);
        run_conv(1'b1, r2, 8'h01);
        chk_mon(r2);
        $display("conversions done");
        report_and_stop();
    end
endmodule
